// >>> verilog/vsgc_pkg.sv
`default_nettype none
package vsgc_pkg;
	localparam int          WORD_BITS    = 16;
	localparam int          WRITE_BIT    = 15;
	localparam logic [6:0]  STATUS_ADDR  = 7'h3C;
	localparam logic [6:0]  CMD_ADDR_LO  = 7'h3E;
	localparam logic [6:0]  CMD_ADDR_HI  = 7'h3F;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] CMD_RESET    = 16'h0000;
	localparam logic [15:0] ESCAPE_WORD  = 16'h00E8;
	localparam logic [15:0] LEVEL_MASK   = 16'h7F03;
	localparam logic [15:0] STICKY_MASK  = 16'h002C;
	// status bit positions
	localparam int ST_SYS_ALARM = 14;
	localparam int ST_SPEC2_X   = 11;
	localparam int ST_SPEC1_X   = 8;
	localparam int ST_READY     = 7;
	localparam int ST_CHECKSUM  = 6;
	localparam int ST_SELFTEST  = 5;
	localparam int ST_ESCAPE    = 4;
	localparam int ST_FRAMING   = 3;
	localparam int ST_FL_UPDATE = 2;
	localparam int ST_SUP_HIGH  = 1;
	localparam int ST_SUP_LOW   = 0;
	// command bit positions
	localparam int CMD_AUTONULL   = 0;
	localparam int CMD_POWERDOWN  = 1;
	localparam int CMD_SELFTEST   = 2;
	localparam int CMD_FACTORY    = 3;
	localparam int CMD_CLR_STATUS = 4;
	localparam int CMD_FLASH_TEST = 5;
	localparam int CMD_SAVE_REGS  = 6;
	localparam int CMD_SW_RESET   = 7;
	localparam int CMD_CLR_REC    = 8;
	localparam int CMD_BAND_ERASE = 9;
	localparam int CMD_BUF_RESET  = 10;
	localparam int CMD_RECORD     = 11;
	localparam int CMD_BAND_SAVE  = 12;
	localparam int CMD_RETRIEVE   = 13;
	localparam int CMD_BAND_LOAD  = 14;
	localparam int CMD_NULL_CLEAR = 15;
endpackage
`default_nettype wire

// >>> verilog/vsgc_status_cmd.sv
// What this block does
// RULE_01: read-only status word at 0x3C, resets zero
// RULE_02: bit 14 follows system alarm threshold crossing
// RULE_03: spectral alarms 2 bits 13-11, 1 bits 10-8
// RULE_04: bit 7 low busy, high data ready
// RULE_05: bit 6 checksum result, bit 2 flash-update failure
// RULE_06: failed self test sets bit 5
// RULE_07: escape word sets bit 4, good recording clears
// RULE_08: non-multiple-of-16 clock edges set bit 3
// RULE_09: bit 1 supply high, bit 0 supply low
// RULE_10: write-only command word 0x3E, bits self clear
// RULE_11: bit 0 autonull, bit 15 discards correction
// RULE_12: bits 14/12/9 band load, save, erase
// RULE_13: bit 13 retrieves records, bit 8 clears them
// RULE_14: bit 11 starts or stops recording
// RULE_15: bit 10 resets buffer read index
// RULE_16: bit 7 software reset, bit 6 saves registers
// RULE_17: bit 5 runs flash checksum test
// RULE_18: bit 4 clears status flags once
// RULE_19: bit 3 restores defaults, empties buffers
// RULE_20: bit 1 sleeps; wake on select or timer
// RULE_21: latching keeps flags until clear command
// RULE_22: without latching flags follow their conditions; bits 5, 3 and 2 still stay set until a clear command
`timescale 1ns/100ps
`default_nettype none
module vsgc_status_cmd (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        SCLK,
	input  wire logic        CS_N,
	input  wire logic        DIN,
	output logic             DOUT,
	output logic             DOUT_OE,
	input  wire logic        LATCH_EN,
	input  wire logic        SYS_ALARM,
	input  wire logic [2:0]  SPEC_ALARM2,
	input  wire logic [2:0]  SPEC_ALARM1,
	input  wire logic        DATA_READY,
	input  wire logic        FLASH_TEST_DONE,
	input  wire logic        FLASH_TEST_FAIL,
	input  wire logic        SELF_TEST_DONE,
	input  wire logic        SELF_TEST_FAIL,
	input  wire logic        FLASH_UPDATE_FAIL,
	input  wire logic        REC_DONE_OK,
	input  wire logic        REC_ACTIVE,
	input  wire logic        SUPPLY_HIGH,
	input  wire logic        SUPPLY_LOW,
	input  wire logic        AUTO_WAKE,
	output logic [15:0]      CMD_PULSE,
	output logic             REC_START,
	output logic             REC_STOP,
	output logic             SLEEP,
	output logic [15:0]      STATUS
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage a feeds only stage b, stage c is for edges
	logic [2:0] sclk_s;
	logic [2:0] cs_s;
	logic [1:0] din_s;
	logic [2:0] next_sclk_s;
	logic [2:0] next_cs_s;
	logic [1:0] next_din_s;

	always_comb begin
		next_sclk_s = {sclk_s[1:0], SCLK};
		next_cs_s   = {cs_s[1:0], CS_N};
		next_din_s  = {din_s[0], DIN};
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_s <= 3'h7;
			cs_s   <= 3'h7;
			din_s  <= 2'h0;
		end else begin
			sclk_s <= next_sclk_s;
			cs_s   <= next_cs_s;
			din_s  <= next_din_s;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	logic cs_low;
	assign sclk_rise = sclk_s[1] & ~sclk_s[2];
	assign sclk_fall = ~sclk_s[1] & sclk_s[2];
	assign cs_fall   = ~cs_s[1] & cs_s[2];
	assign cs_rise   = cs_s[1] & ~cs_s[2];
	assign cs_low    = ~cs_s[1];

	////////////////////////////////////////////////////////////////////////////
	// serial slave: mode 3, 16-bit words, write = 1 addr[6:0] data[7:0]
	logic [3:0]  bit_cnt;
	logic [15:0] rx;
	logic [15:0] tx;
	logic        oe;
	logic [3:0]  next_bit_cnt;
	logic [15:0] next_rx;
	logic [15:0] next_tx;
	logic        next_oe;
	logic [15:0] word_in;
	logic        word_done;
	logic        is_write;
	logic [6:0]  word_addr;
	logic        frame_err;
	logic        escape_hit;
	logic [15:0] status;

	assign word_in   = {rx[14:0], din_s[1]};
	assign word_done = cs_low & sclk_rise & (bit_cnt == 4'hF);
	assign is_write  = word_in[vsgc_pkg::WRITE_BIT];
	assign word_addr = word_in[14:8];
	assign frame_err  = cs_rise & (bit_cnt != 4'h0); // [RULE_08]
	assign escape_hit = word_done & (word_in == vsgc_pkg::ESCAPE_WORD); // [RULE_07]

	always_comb begin
		next_bit_cnt = bit_cnt;
		next_rx      = rx;
		next_tx      = tx;
		next_oe      = cs_low;
		if (cs_fall) begin
			next_bit_cnt = 4'h0;
		end else if (cs_low && sclk_rise) begin
			next_bit_cnt = bit_cnt + 4'h1;
			next_rx      = word_in;
		end
		if (cs_low && sclk_fall && bit_cnt != 4'h0) begin
			next_tx = {tx[14:0], 1'b0};
		end
		if (word_done) begin
			next_tx = 16'h0000;
			if (!is_write && word_addr[6:1] == vsgc_pkg::STATUS_ADDR[6:1]) begin
				next_tx = status; // [RULE_01]
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bit_cnt <= 4'h0;
			rx      <= 16'h0000;
			tx      <= 16'h0000;
			oe      <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			rx      <= next_rx;
			tx      <= next_tx;
			oe      <= next_oe;
		end
	end

	assign DOUT    = tx[15];
	assign DOUT_OE = oe;

	////////////////////////////////////////////////////////////////////////////
	// command word: one-cycle pulses, nothing stored, so it self clears
	logic [15:0] cmd;
	logic        rec_start;
	logic        rec_stop;
	logic        sleep;
	logic [15:0] next_cmd;
	logic        next_rec_start;
	logic        next_rec_stop;
	logic        next_sleep;

	always_comb begin
		next_cmd       = vsgc_pkg::CMD_RESET; // [RULE_10]
		next_rec_start = 1'b0;
		next_rec_stop  = 1'b0;
		if (word_done && is_write) begin
			if (word_addr == vsgc_pkg::CMD_ADDR_LO) begin
				next_cmd[7:0] = word_in[7:0]; // [RULE_11] [RULE_16] [RULE_17] [RULE_19]
			end else if (word_addr == vsgc_pkg::CMD_ADDR_HI) begin
				next_cmd[15:8] = word_in[7:0]; // [RULE_12] [RULE_13] [RULE_15]
				next_rec_start = word_in[vsgc_pkg::CMD_RECORD - 8] & ~REC_ACTIVE; // [RULE_14]
				next_rec_stop  = word_in[vsgc_pkg::CMD_RECORD - 8] & REC_ACTIVE;
			end
		end
		next_sleep = sleep;
		if (cmd[vsgc_pkg::CMD_POWERDOWN]) begin
			next_sleep = 1'b1; // [RULE_20]
		end else if (cs_fall || cs_rise || AUTO_WAKE) begin
			next_sleep = 1'b0; // [RULE_20]
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmd       <= vsgc_pkg::CMD_RESET;
			rec_start <= 1'b0;
			rec_stop  <= 1'b0;
			sleep     <= 1'b0;
		end else begin
			cmd       <= next_cmd;
			rec_start <= next_rec_start;
			rec_stop  <= next_rec_stop;
			sleep     <= next_sleep;
		end
	end

	assign CMD_PULSE = cmd;
	assign REC_START = rec_start;
	assign REC_STOP  = rec_stop;
	assign SLEEP     = sleep;

	////////////////////////////////////////////////////////////////////////////
	// status flags; a setting cause always wins over the clear
	logic [15:0] next_status;
	logic [15:0] held;
	logic [15:0] level;
	logic [15:0] events;
	logic        clear_all;

	assign clear_all = cmd[vsgc_pkg::CMD_CLR_STATUS] | cmd[vsgc_pkg::CMD_SW_RESET]
		| cmd[vsgc_pkg::CMD_FACTORY]; // [RULE_18]

	always_comb begin
		held  = clear_all ? vsgc_pkg::STATUS_RESET : status;
		level = 16'h0000;
		level[vsgc_pkg::ST_SYS_ALARM]                       = SYS_ALARM; // [RULE_02]
		level[vsgc_pkg::ST_SPEC2_X +: 3]                    = SPEC_ALARM2; // [RULE_03]
		level[vsgc_pkg::ST_SPEC1_X +: 3]                    = SPEC_ALARM1; // [RULE_03]
		level[vsgc_pkg::ST_SUP_HIGH]                        = SUPPLY_HIGH; // [RULE_09]
		level[vsgc_pkg::ST_SUP_LOW]                         = SUPPLY_LOW; // [RULE_09]
		events = 16'h0000;
		events[vsgc_pkg::ST_SELFTEST]  = SELF_TEST_DONE & SELF_TEST_FAIL; // [RULE_06]
		events[vsgc_pkg::ST_FRAMING]   = frame_err; // [RULE_08]
		events[vsgc_pkg::ST_FL_UPDATE] = FLASH_UPDATE_FAIL; // [RULE_05]
		next_status = 16'h0000;
		if (LATCH_EN) begin
			next_status = (held | level) & vsgc_pkg::LEVEL_MASK; // [RULE_21]
		end else begin
			next_status = level & vsgc_pkg::LEVEL_MASK; // [RULE_22]
		end
		next_status = next_status | ((held | events) & vsgc_pkg::STICKY_MASK);
		next_status[vsgc_pkg::ST_READY] = DATA_READY; // [RULE_04]
		if (FLASH_TEST_DONE) begin
			next_status[vsgc_pkg::ST_CHECKSUM] = FLASH_TEST_FAIL
				| (LATCH_EN & held[vsgc_pkg::ST_CHECKSUM]); // [RULE_05] [RULE_21]
		end else begin
			next_status[vsgc_pkg::ST_CHECKSUM] = held[vsgc_pkg::ST_CHECKSUM];
		end
		if (escape_hit) begin
			next_status[vsgc_pkg::ST_ESCAPE] = 1'b1; // [RULE_07]
		end else if (REC_DONE_OK) begin
			next_status[vsgc_pkg::ST_ESCAPE] = 1'b0; // [RULE_07]
		end else begin
			next_status[vsgc_pkg::ST_ESCAPE] = held[vsgc_pkg::ST_ESCAPE];
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			status <= vsgc_pkg::STATUS_RESET; // [RULE_01]
		end else begin
			status <= next_status;
		end
	end

	assign STATUS = status;

endmodule
`default_nettype wire

// >>> sim/vsgc_status_cmd_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module vsgc_status_cmd_asserts (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        LATCH_EN,
	input wire logic        SYS_ALARM,
	input wire logic        DATA_READY,
	input wire logic        SELF_TEST_DONE,
	input wire logic        SELF_TEST_FAIL,
	input wire logic        CS_N,
	input wire logic        AUTO_WAKE,
	input wire logic [15:0] CMD_PULSE,
	input wire logic        SLEEP,
	input wire logic        DOUT_OE,
	input wire logic [15:0] STATUS
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_spare_bit_zero: assert property (!STATUS[15])
		else $error("spare status bit set");
	a_ready_live: assert property (!$stable(DATA_READY) |=> STATUS[7] == $past(DATA_READY))
		else $error("ready bit lags");
	a_alarm_follows: assert property ($past(RST_N) && !$past(LATCH_EN) |-> STATUS[14] == $past(SYS_ALARM))
		else $error("alarm bit stale");
	a_latch_holds: assert property (LATCH_EN && STATUS[14] && !(|(CMD_PULSE & 16'h0098)) |=> STATUS[14])
		else $error("latched alarm dropped");
	a_clear_once: assert property (CMD_PULSE[4] && !SELF_TEST_DONE |=> !STATUS[5])
		else $error("clear left flag");
	a_selftest_flag: assert property (SELF_TEST_DONE && SELF_TEST_FAIL |=> STATUS[5])
		else $error("self test flag missing");
	a_sleep_entry: assert property (CMD_PULSE[1] |=> SLEEP)
		else $error("no sleep");
	a_pulse_single: assert property (|CMD_PULSE |=> CMD_PULSE == 16'h0000)
		else $error("command bit stuck");
	a_oe_follows: assert property (DOUT_OE == !$past(CS_N, 3))
		else $error("output enable off select");
	a_timer_wake: assert property (AUTO_WAKE && !CMD_PULSE[1] |=> !SLEEP)
		else $error("timer did not wake");
endmodule
`default_nettype wire

// >>> sim/vsgc_host.sv
`timescale 1ns/100ps
`default_nettype none
module vsgc_host (
	input  wire logic CLK,
	output logic      SCLK,
	output logic      CS_N,
	output logic      DIN,
	input  wire logic DOUT
);
	initial begin
		SCLK = 1'b1;
		CS_N = 1'b1;
		DIN  = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge CLK);
	endtask
	// n edges, msb first; sends whatever word w holds, read or write
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		CS_N = 1'b0;
		hold(4);
		for (int i = 0; i < n; i++) begin
			SCLK = 1'b0;
			DIN  = w[15 - i % 16];
			hold(4);
			SCLK = 1'b1;
			r    = {r[14:0], DOUT};
			hold(4);
		end
		CS_N = 1'b1; // select toggle wakes
		DIN  = ~DIN;
		hold(6);
	endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        CLK, RST_N, SCLK, CS_N, DIN, DOUT, DOUT_OE, LATCH_EN, SYS_ALARM, DATA_READY, FLASH_TEST_DONE;
	logic        FLASH_TEST_FAIL, SELF_TEST_DONE, SELF_TEST_FAIL, FLASH_UPDATE_FAIL, REC_DONE_OK, REC_ACTIVE;
	logic        SUPPLY_HIGH, SUPPLY_LOW, AUTO_WAKE, REC_START, REC_STOP, SLEEP, got_sleep;
	logic [2:0]  SPEC_ALARM2, SPEC_ALARM1;
	logic [15:0] CMD_PULSE, STATUS, rx, got_cmd;
	logic [1:0]  got_rec;
	int          num_errors = 0;
	int          checks_done = 0;
	logic        miso;
	// a deselected output shows the inverse so a late sample is caught
	assign miso = DOUT_OE ? DOUT : ~DOUT;
	vsgc_status_cmd i_vsgc_status_cmd (.CLK, .RST_N, .SCLK, .CS_N, .DIN, .DOUT, .DOUT_OE, .LATCH_EN, .SYS_ALARM,
		.SPEC_ALARM2, .SPEC_ALARM1, .DATA_READY, .FLASH_TEST_DONE, .FLASH_TEST_FAIL, .SELF_TEST_DONE,
		.SELF_TEST_FAIL, .FLASH_UPDATE_FAIL, .REC_DONE_OK, .REC_ACTIVE, .SUPPLY_HIGH, .SUPPLY_LOW, .AUTO_WAKE,
		.CMD_PULSE, .REC_START, .REC_STOP, .SLEEP, .STATUS);
	vsgc_host i_vsgc_host (.CLK, .SCLK, .CS_N, .DIN, .DOUT(miso));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task automatic pls(input logic [6:0] v);
		{SELF_TEST_DONE, SELF_TEST_FAIL, FLASH_UPDATE_FAIL, FLASH_TEST_DONE, FLASH_TEST_FAIL, REC_DONE_OK, AUTO_WAKE} = v;
		cyc(1);
		{SELF_TEST_DONE, SELF_TEST_FAIL, FLASH_UPDATE_FAIL, FLASH_TEST_DONE, FLASH_TEST_FAIL, REC_DONE_OK, AUTO_WAKE} = '0;
		cyc(3);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_vsgc_host.xfer({1'b1, a, d}, 16, rx);
		cyc(4);
	endtask
	task automatic t_levels();
		{SYS_ALARM, SPEC_ALARM2, SPEC_ALARM1, DATA_READY, SUPPLY_HIGH} = 9'h1AB;
		cyc(3);
		chk(STATUS, 16'h6A82);
		i_vsgc_host.xfer({1'b0, vsgc_pkg::STATUS_ADDR, 8'h00}, 32, rx);
		chk(rx, 16'h6A82);
		{SYS_ALARM, SPEC_ALARM2, SPEC_ALARM1, DATA_READY, SUPPLY_HIGH, SUPPLY_LOW} = 10'h001;
		cyc(3);
		chk(STATUS, 16'h0001);
		SUPPLY_LOW = 1'b0;
	endtask
	task automatic t_sticky();
		pls(7'h7C);
		i_vsgc_host.xfer(vsgc_pkg::ESCAPE_WORD, 16, rx);
		i_vsgc_host.xfer(16'h0000, 12, rx);
		chk(STATUS, 16'h007C);
		pls(7'h08);
		chk(STATUS, 16'h003C);
		pls(7'h02);
		chk(STATUS, 16'h002C);
		wr(vsgc_pkg::CMD_ADDR_LO, 8'h10);
		chk(STATUS, 16'h0000);
	endtask
	task automatic t_latch();
		LATCH_EN = 1'b1;
		SYS_ALARM = 1'b1;
		cyc(1);
		SYS_ALARM = 1'b0;
		cyc(3);
		chk(STATUS, 16'h4000);
		wr(vsgc_pkg::CMD_ADDR_LO, 8'h10);
		chk(STATUS, 16'h0000);
		LATCH_EN = 1'b0;
	endtask
	task automatic t_wake();
		@(posedge SLEEP);
		@(negedge CLK);
		AUTO_WAKE = 1'b1;
		cyc(1);
		AUTO_WAKE = 1'b0;
		chk({15'h0, SLEEP}, 16'h0000);
	endtask
	task automatic t_cmds();
		for (int i = 0; i < 16; i++) begin
			got_cmd = '0;
			got_sleep = 1'b0;
			REC_ACTIVE = (i == 11);
			fork
				wr(i < 8 ? vsgc_pkg::CMD_ADDR_LO : vsgc_pkg::CMD_ADDR_HI, 8'(1 << (i % 8)));
				if (i == 1) t_wake();
			join
			chk(got_cmd, 16'(1 << i));
			if (i == 1) chk({14'h0, got_sleep, SLEEP}, 16'h0002);
			if (i == 11) chk({14'h0, got_rec}, 16'h0001);
		end
		REC_ACTIVE = 1'b0;
		wr(vsgc_pkg::CMD_ADDR_HI, 8'h08);
		chk({14'h0, got_rec}, 16'h0002);
		got_cmd = '0;
		wr(vsgc_pkg::STATUS_ADDR, 8'hFF);
		pls(7'h01);
		chk(got_cmd, 16'h0000);
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(negedge CLK) begin
		if (|CMD_PULSE) begin
			got_cmd = CMD_PULSE;
			got_rec = {REC_START, REC_STOP};
		end
		got_sleep = got_sleep | SLEEP;
	end
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	initial begin
		RST_N = 1'b0;
		{LATCH_EN, SYS_ALARM, SPEC_ALARM2, SPEC_ALARM1, DATA_READY, SUPPLY_HIGH, SUPPLY_LOW, REC_ACTIVE} = '0;
		{SELF_TEST_DONE, SELF_TEST_FAIL, FLASH_UPDATE_FAIL, FLASH_TEST_DONE, FLASH_TEST_FAIL, REC_DONE_OK, AUTO_WAKE} = '0;
		cyc(3);
		RST_N = 1'b1;
		cyc(4);
		i_vsgc_host.xfer({1'b0, vsgc_pkg::STATUS_ADDR, 8'h00}, 32, rx);
		chk(rx, vsgc_pkg::STATUS_RESET);
		t_levels();
		t_sticky();
		t_latch();
		t_cmds();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge CLK);
		num_errors++;
		end_of_test();
	end
endmodule
bind vsgc_status_cmd vsgc_status_cmd_asserts i_chk (.CLK, .RST_N, .LATCH_EN, .SYS_ALARM, .DATA_READY,
	.SELF_TEST_DONE, .SELF_TEST_FAIL, .CS_N, .AUTO_WAKE, .CMD_PULSE, .SLEEP, .DOUT_OE, .STATUS);
`default_nettype wire
